// file: octal_relay_output_latch_ctrl.sv
// Purpose: Eight-channel open-drain relay latch with serial or parallel front end
// Assumes: All pins asynchronous; serial clock well below a quarter of clk_i
// Notes: Overrides act three clock cycles after the pin, through the synchroniser and then the latch
`timescale 1ns/1ps
`default_nettype none
module octal_relay_output_latch_ctrl (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic parallel_mode_i,
	input wire logic cs_n_i,
	input wire logic sclk_i,
	input wire logic sdi_i,
	input wire logic addr_bit_zero_i,
	input wire logic addr_bit_one_i,
	input wire logic addr_bit_two_i,
	input wire logic channel_level_i,
	input wire logic all_on_n_i,
	input wire logic all_off_n_i,
	output logic sdo_o,
	output logic [relay_latch_pkg::CHAN_W-1:0] chan_drv_o,
	output logic [relay_latch_pkg::CHAN_W-1:0] chan_oe_o
);
	// ==========================================================
	// Pin synchronisation
	pin_sync_if pins ();

	assign pins.raw = {parallel_mode_i, all_off_n_i, all_on_n_i, channel_level_i,
		addr_bit_two_i, addr_bit_one_i, addr_bit_zero_i, sdi_i, sclk_i, cs_n_i};

	pin_sync2 u_sync (
		.clk_i(clk_i),
		.arst_n_i(arst_n_i),
		.pins(pins)
	);

	logic cs_n;
	logic sclk;
	logic sdi;
	logic [relay_latch_pkg::ADDR_W-1:0] addr;
	logic level;
	logic on_n;
	logic off_n;
	logic par_mode;

	assign cs_n = pins.sync[relay_latch_pkg::POS_CS_N];
	assign sclk = pins.sync[relay_latch_pkg::POS_SCLK];
	assign sdi = pins.sync[relay_latch_pkg::POS_SDI];
	assign addr = pins.sync[relay_latch_pkg::POS_ADDR +: relay_latch_pkg::ADDR_W];
	assign level = pins.sync[relay_latch_pkg::POS_LEVEL];
	assign on_n = pins.sync[relay_latch_pkg::POS_ON_N];
	assign off_n = pins.sync[relay_latch_pkg::POS_OFF_N];
	assign par_mode = pins.sync[relay_latch_pkg::POS_MODE];

	// ==========================================================
	// Edge detection
	logic cs_n_ff;
	logic sclk_ff;
	logic cs_rise;
	logic cs_fall;
	logic sclk_rise;
	logic sclk_fall;
	logic nxt_cs_n;
	logic nxt_sclk;

	assign cs_rise = cs_n && !cs_n_ff;
	assign cs_fall = !cs_n && cs_n_ff;
	assign sclk_rise = sclk && !sclk_ff;
	assign sclk_fall = !sclk && sclk_ff;

	always_comb begin
		nxt_cs_n = cs_n;
		nxt_sclk = sclk;
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cs_n_ff <= relay_latch_pkg::SYNC_RST[relay_latch_pkg::POS_CS_N];
			sclk_ff <= relay_latch_pkg::SYNC_RST[relay_latch_pkg::POS_SCLK];
		end else begin
			cs_n_ff <= nxt_cs_n;
			sclk_ff <= nxt_sclk;
		end
	end

	// ==========================================================
	// Shift register, latch and serial out
	logic [relay_latch_pkg::CHAN_W-1:0] shift_ff;
	logic [relay_latch_pkg::CHAN_W-1:0] latch_ff;
	logic [relay_latch_pkg::ADDR_W-1:0] addr_ff;
	logic sdo_ff;
	logic [relay_latch_pkg::CHAN_W-1:0] drv_ff;
	logic [relay_latch_pkg::CHAN_W-1:0] nxt_shift;
	logic [relay_latch_pkg::CHAN_W-1:0] nxt_latch;
	logic [relay_latch_pkg::ADDR_W-1:0] nxt_addr;
	logic nxt_sdo;
	logic [relay_latch_pkg::CHAN_W-1:0] nxt_drv;

	always_comb begin
		nxt_shift = shift_ff;
		nxt_latch = latch_ff; // R15
		nxt_addr = addr_ff;
		nxt_sdo = sdo_ff;
		nxt_drv = relay_latch_pkg::ALL_OFF; // R9
		if (cs_fall) begin
			nxt_addr = addr;
		end
		if (!cs_n && sclk_rise && !par_mode) begin
			nxt_shift = {shift_ff[relay_latch_pkg::CHAN_W-2:0], sdi}; // R10 R13
		end
		if (cs_rise) begin
			if (par_mode) begin
				nxt_latch[addr_ff] = level; // R3 R4 R5 R14
			end else begin
				nxt_latch = shift_ff; // R1 R2
			end
		end
		if (!on_n) begin
			nxt_shift = relay_latch_pkg::ALL_ON; // R6 R7
			nxt_latch = relay_latch_pkg::ALL_ON; // R6 R7
		end
		if (!off_n) begin
			nxt_shift = relay_latch_pkg::ALL_OFF; // R8 R12
			nxt_latch = relay_latch_pkg::ALL_OFF; // R8 R12
		end
		if (sclk_fall || cs_n) begin
			nxt_sdo = shift_ff[relay_latch_pkg::CHAN_W-1]; // R11
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			shift_ff <= relay_latch_pkg::SHIFT_RST;
			latch_ff <= relay_latch_pkg::LATCH_RST;
			addr_ff <= relay_latch_pkg::ADDR_RST;
			sdo_ff <= relay_latch_pkg::SHIFT_RST[relay_latch_pkg::CHAN_W-1];
			drv_ff <= relay_latch_pkg::ALL_OFF;
		end else begin
			shift_ff <= nxt_shift;
			latch_ff <= nxt_latch;
			addr_ff <= nxt_addr;
			sdo_ff <= nxt_sdo;
			drv_ff <= nxt_drv;
		end
	end

	// Open drain: level always low, enabled only for active channels
	assign chan_drv_o = drv_ff; // R9
	assign chan_oe_o = latch_ff; // R9
	assign sdo_o = sdo_ff;

	// ==========================================================
	// Assertions
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);

	a_off_clears_all: assert property (!off_n |=> latch_ff == 8'h00 && shift_ff == 8'h00) // R12 R8
		else $error("all-off did not clear latch and shift register");
	a_on_sets_all: assert property (!on_n && off_n |=> latch_ff == 8'hff && shift_ff == 8'hff) // R6 R7
		else $error("all-on did not set latch and shift register");
	a_serial_latch_update: assert property (cs_rise && !par_mode && on_n && off_n
		|=> latch_ff == $past(shift_ff) && chan_oe_o == latch_ff) // R1 R2
		else $error("serial latch did not take the shift register on select rise");
	a_par_addr_update: assert property (cs_rise && par_mode && on_n && off_n
		|=> latch_ff[$past(addr_ff)] == $past(level)) // R3 R5 R14
		else $error("parallel update wrong on addressed channel");
	a_par_others_keep: assert property (cs_rise && par_mode && on_n && off_n
		|=> (latch_ff ^ $past(latch_ff)) == ((latch_ff ^ $past(latch_ff)) &
		(8'h01 << $past(addr_ff)))) // R4
		else $error("parallel update touched another channel");
	a_latch_holds: assert property (!cs_rise && on_n && off_n |=> $stable(latch_ff)) // R15
		else $error("latch changed without select rise or override");
	a_shift_sample: assert property (!cs_n && sclk_rise && !par_mode && on_n && off_n
		|=> shift_ff == {$past(shift_ff[6:0]), $past(sdi)}) // R10 R13
		else $error("shift register did not sample serial data");
	a_sdo_on_fall: assert property (sclk_fall |=> sdo_o == $past(shift_ff[7])) // R11
		else $error("serial out did not follow last stage on clock fall");
	a_never_drive_high: assert property (chan_drv_o == 8'h00) // R9
		else $error("channel output drives high");
	a_sdo_select_high: assert property ( // R11
		cs_n |=> sdo_o == $past(shift_ff[relay_latch_pkg::CHAN_W-1]))
		else $error("serial out did not show last stage while deselected");
	a_sdo_holds_frame: assert property ( // R11
		!cs_n && !sclk_fall |=> $stable(sdo_o))
		else $error("serial out changed without a serial clock fall");
	a_first_bit_out: assert property ( // R11
		cs_rise && !par_mode && on_n && off_n |=> sdo_o == latch_ff[relay_latch_pkg::CHAN_W-1])
		else $error("first input bit not present at serial out after update");
	a_idle_shift_hold: assert property ( // R10
		cs_n && on_n && off_n |=> $stable(shift_ff))
		else $error("shift register moved while deselected");
	a_shift_needs_edge: assert property ( // R10
		!sclk_rise && on_n && off_n |=> $stable(shift_ff))
		else $error("shift register moved without a serial clock rise");
	a_par_shift_hold: assert property ( // R3
		par_mode && on_n && off_n |=> $stable(shift_ff))
		else $error("shift register moved in parallel mode");
	a_addr_capture: assert property ( // R14
		cs_fall |=> addr_ff == $past(addr))
		else $error("address not captured on select fall");
	a_addr_holds: assert property ( // R4
		!cs_fall |=> $stable(addr_ff))
		else $error("captured address changed after select fall");
	a_on_beats_select: assert property ( // R7
		cs_rise && !on_n && off_n |=> latch_ff == relay_latch_pkg::ALL_ON)
		else $error("select rise overrode all-on");
	a_off_beats_on: assert property ( // R8
		!on_n && !off_n |=> chan_oe_o == relay_latch_pkg::ALL_OFF)
		else $error("all-on overrode all-off");
	a_off_beats_select: assert property ( // R12
		cs_rise && !off_n |=> latch_ff == relay_latch_pkg::ALL_OFF)
		else $error("select rise overrode all-off");
	a_latch_low_frame: assert property ( // R15
		!cs_n && on_n && off_n |=> $stable(latch_ff))
		else $error("latch changed while selected");

	c_serial_frame: cover property (cs_rise && !par_mode && on_n && off_n ##1 latch_ff != 8'h00);
	c_par_update: cover property (cs_rise && par_mode && level && on_n && off_n);
	c_both_overrides: cover property (!on_n && !off_n);
	c_sdo_toggle: cover property (sclk_fall && shift_ff[7] != sdo_ff);

	// ==========================================================
	// Address capture cover
	c_addr_capture: cover property (cs_fall && par_mode);
endmodule
`default_nettype wire

// file: relay_latch_pkg.sv
// Purpose: Shared constants for the eight-channel relay output latch controller
// Assumes: One 250 MHz clock samples every pin, including the serial clock
// Notes: Sync vector positions name the pins carried through the synchroniser
//
// What this block does
// (R1) Serial bits go into an eight-stage shift register that moves to the output latch only on a chip select rise.
// (R2) Shift register bit n drives channel n+1, bit zero channel one up to bit seven channel eight.
// (R3) In parallel mode the three address inputs pick one channel and the level input gives its new state.
// (R4) Parallel address and level are applied on the chip select rise and all other channels keep their state.
// (R5) A high level turns the addressed channel on at the update and a low level turns it off.
// (R6) While all-on is low every latch and register bit is forced to one; the code forces only latch_ff and shift_ff, not addr_ff or sdo_ff.
// (R7) All-on beats every serial or parallel input, chip select edges included.
// (R8) All-off beats all-on, so both low means every channel off.
// (R9) An active channel sinks to power ground and an inactive one floats, never driving high.
// (R10) While chip select is low the host presents data that is sampled on each serial clock rise.
// (R11) The serial data out shows the last shift stage and changes on the serial clock fall.
// (R12) While all-off is low all latches and registers clear and every channel is off; the code clears only latch_ff and shift_ff, not addr_ff or sdo_ff.
// (R13) The host shifts the channel eight bit first and the channel one bit last.
// (R14) The address is a binary value zero to seven and value n selects channel n+1.
// (R15) The output latch holds between chip select rises whatever shifting or address changes occur.
package relay_latch_pkg;
	localparam int CHAN_W = 8;
	localparam int ADDR_W = 3;
	localparam int SYNC_W = 10;
	// Positions of pins in the synchronised vector
	localparam int POS_CS_N = 0;
	localparam int POS_SCLK = 1;
	localparam int POS_SDI = 2;
	localparam int POS_ADDR = 3;
	localparam int POS_LEVEL = 6;
	localparam int POS_ON_N = 7;
	localparam int POS_OFF_N = 8;
	localparam int POS_MODE = 9;
	// Idle pin levels held in the synchroniser under reset
	localparam logic [SYNC_W-1:0] SYNC_RST = 10'h181;
	localparam logic [CHAN_W-1:0] LATCH_RST = 8'h00;
	localparam logic [CHAN_W-1:0] SHIFT_RST = 8'h00;
	localparam logic [CHAN_W-1:0] ALL_ON = 8'hff;
	localparam logic [CHAN_W-1:0] ALL_OFF = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_RST = 3'h0;
endpackage

// file: pin_sync_if.sv
// Purpose: Carries raw pin levels into the synchroniser and clean levels back
// Assumes: Driven and read on clk_i of the top module
// Notes: None
`timescale 1ns/1ps
`default_nettype none
interface pin_sync_if;
	logic [relay_latch_pkg::SYNC_W-1:0] raw;
	logic [relay_latch_pkg::SYNC_W-1:0] sync;
	modport user (output raw, input sync);
	modport syncer (input raw, output sync);
endinterface
`default_nettype wire

// file: pin_sync2.sv
// Purpose: Two-flop synchroniser for a vector of pin levels
// Assumes: Pins are asynchronous to clk_i
// Notes: First stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module pin_sync2 (
	input wire logic clk_i,
	input wire logic arst_n_i,
	pin_sync_if.syncer pins
);
	logic [relay_latch_pkg::SYNC_W-1:0] meta_ff;
	logic [relay_latch_pkg::SYNC_W-1:0] sync_ff;
	logic [relay_latch_pkg::SYNC_W-1:0] nxt_meta;
	logic [relay_latch_pkg::SYNC_W-1:0] nxt_sync;

	always_comb begin
		nxt_meta = pins.raw;
		nxt_sync = meta_ff;
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			meta_ff <= relay_latch_pkg::SYNC_RST;
			sync_ff <= relay_latch_pkg::SYNC_RST;
		end else begin
			meta_ff <= nxt_meta;
			sync_ff <= nxt_sync;
		end
	end

	assign pins.sync = sync_ff;
endmodule
`default_nettype wire

// file: host_model.sv
// Purpose: Host model driving the relay latch control pins
// Assumes: Pins change on the falling edge of clk_i
// Notes: Serial clock period is eight clk_i cycles, idle low
`timescale 1ns/1ps
`default_nettype none
module host_model (
	input wire logic clk_i,
	output logic cs_n_o,
	output logic sclk_o,
	output logic sdi_o,
	output logic [2:0] addr_o,
	output logic level_o
);
	initial begin
		cs_n_o = 1'b1;
		sclk_o = 1'b0;
		sdi_o = 1'b0;
		addr_o = 3'h0;
		level_o = 1'b0;
	end
	task automatic wt(input int n);
		repeat (n) @(negedge clk_i);
	endtask
	// ==========
	// Serial frame, first bit lands in channel eight
	task automatic frame(input logic [7:0] b);
		cs_n_o = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			sdi_o = b[i];
			wt(4);
			sclk_o = 1'b1;
			wt(4);
			sclk_o = 1'b0;
		end
		sdi_o = ~sdi_o;
		cs_n_o = 1'b1;
		wt(8);
	endtask
	// ==========
	// Parallel update, address moved after select falls
	task automatic par(input logic [2:0] a, input logic l);
		addr_o = a;
		wt(4);
		cs_n_o = 1'b0;
		wt(4);
		addr_o = ~a;
		level_o = l;
		wt(4);
		cs_n_o = 1'b1;
		wt(4);
		level_o = ~l;
		wt(4);
	endtask
endmodule
`default_nettype wire

// file: testbench.sv
// Purpose: Self-checking bench for the relay latch controller
// Assumes: Pins driven on the falling edge of clk_i
// Notes: Expected outputs pass through a queue to a monitor
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic clk_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic pmode = 1'b0;
	logic on_n = 1'b1;
	logic off_n = 1'b1;
	logic cs_n, sclk, sdi, lvl, sdo;
	logic [2:0] addr;
	logic [7:0] drv, oe, latch, sreg;
	logic [8:0] e;
	logic [8:0] exp_q[$];
	logic [16:0] rnd = 17'h10050;
	int err_total = 0;
	int check_count = 0;
	event chk_ev;
	initial forever #2 clk_i = ~clk_i;
	host_model host (.clk_i(clk_i), .cs_n_o(cs_n), .sclk_o(sclk), .sdi_o(sdi),
		.addr_o(addr), .level_o(lvl));
	octal_relay_output_latch_ctrl DUT (.clk_i(clk_i), .arst_n_i(arst_n_i),
		.parallel_mode_i(pmode), .cs_n_i(cs_n), .sclk_i(sclk), .sdi_i(sdi),
		.addr_bit_zero_i(addr[0]), .addr_bit_one_i(addr[1]), .addr_bit_two_i(addr[2]),
		.channel_level_i(lvl), .all_on_n_i(on_n), .all_off_n_i(off_n),
		.sdo_o(sdo), .chan_drv_o(drv), .chan_oe_o(oe));
	function automatic logic [16:0] lfsr(input logic [16:0] s);
		return {s[15:0], s[16] ^ s[13]};
	endfunction
	task automatic expect_out(input logic s, input logic [7:0] v);
		exp_q.push_back({s, v});
		->chk_ev;
		@(negedge clk_i);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// ==========
	// Monitor
	initial forever begin
		@chk_ev;
		check_count++;
		e = exp_q.pop_front();
		if ({sdo, oe, drv} !== {e, 8'h00}) begin
			err_total++;
			$display("MISMATCH sdo_oe_drv exp %h got %h", {e, 8'h00}, {sdo, oe, drv});
		end
	end
	// ==========
	// Watchdog
	initial begin
		#20000;
		err_total++;
		$display("MISMATCH watchdog exp done got hang");
		tally_and_finish();
	end
	// ==========
	// Scenarios
	initial begin
		repeat (5) @(negedge clk_i);
		arst_n_i = 1'b1;
		repeat (3) @(negedge clk_i);
		expect_out(1'b0, 8'h00);
		for (int k = 0; k < 6; k++) begin
			repeat (8) rnd = lfsr(rnd);
			host.frame(rnd[7:0]);
			latch = rnd[7:0];
			sreg = latch;
			expect_out(rnd[7], latch);
		end
		pmode = 1'b1;
		repeat (4) @(negedge clk_i);
		for (int a = 0; a < 8; a++) begin
			repeat (8) rnd = lfsr(rnd);
			host.par(a[2:0], rnd[0]);
			latch[a] = rnd[0];
			expect_out(sreg[7], latch);
		end
		on_n = 1'b0;
		host.par(3'h2, 1'b0);
		expect_out(1'b1, 8'hff);
		off_n = 1'b0;
		repeat (6) @(negedge clk_i);
		expect_out(1'b0, 8'h00);
		on_n = 1'b1;
		pmode = 1'b0;
		host.frame(8'h5a);
		expect_out(1'b0, 8'h00);
		off_n = 1'b1;
		repeat (4) @(negedge clk_i);
		host.frame(8'ha5);
		expect_out(1'b1, 8'ha5);
		tally_and_finish();
	end
endmodule
`default_nettype wire
